// ### hw/pte_top.v
// Peripheral transfer engine for one receive/transmit channel pair: register
// slave, enable control, and the engine that moves one unit per request.
// Assumes one 250 MHz clock, synchronous active-high reset, a register master
// that never waits, and a memory bus that answers each request with an ack.
//
// Operation
// - Receive pointer, 32 bits read/write, at offset 0x100.
// - Receive count, bits 15..0 read/write, at offset 0x104.
// - Transmit pointer, 32 bits read/write, at offset 0x108.
// - Transmit count at 0x10C; transmit transfers stop at zero.
// - Receive next pointer, 32 bits, at offset 0x110.
// - Receive next count, 16 bits, at offset 0x114.
// - Transmit next pointer, 32 bits, at offset 0x118.
// - Transmit next count, 16 bits, at offset 0x11C.
// - Control bit 0 enables receive requests unless bit 1 also written.
// - Control bit 1 disables receive requests; zero leaves state.
// - Control bit 8 enables transmit requests; zero has no effect.
// - Control bit 9 disables transmit requests; zero has no effect.
// - Status bit 0 shows receive enable; resets to zero.
// - Status bit 8 shows transmit enable.
// - Registers sit at the same offsets within each peripheral window.
// - Each transfer advances pointer by 1, 2 or 4 and decrements count.
// - At zero count with a nonzero next count, next pointer and count load; next count clears.
// - End flag at zero count; all-done flag when both counts zero.
// - Writing either count of a direction clears its end flag, except a next-count write in the cycle a step reaches zero.
//
// The address-and-strobe port was left to the implementer.
`include "pte_defines.vh"

module pte_top #(
  parameter ADDR_W = 12,
  parameter PTR_W  = 32
) (
  input  wire              clk_i,
  input  wire              srst_i,
  // Register port.
  input  wire [ADDR_W-1:0] reg_addr_i,
  input  wire [31:0]       reg_wdata_i,
  input  wire              reg_we_i,
  input  wire              reg_re_i,
  output wire [31:0]       reg_rdata_o,
  // Transfer size for both channels.
  input  wire [1:0]        xfer_size_i,
  // Serial peripheral side.
  input  wire              peripheral_rx_request_i,
  input  wire [31:0]       rx_data_i,
  output wire              rx_taken_o,
  input  wire              peripheral_tx_request_i,
  output wire [31:0]       tx_data_o,
  output wire              tx_load_o,
  output wire              rx_buffer_done_o,
  output wire              rx_all_buffers_full_o,
  output wire              tx_buffer_done_o,
  output wire              tx_all_buffers_empty_o,
  // Memory bus side.
  output wire              mem_req_o,
  output wire              mem_we_o,
  output wire [PTR_W-1:0]  mem_addr_o,
  output wire [1:0]        mem_size_o,
  output wire [31:0]       mem_wdata_o,
  input  wire [31:0]       mem_rdata_i,
  input  wire              mem_ack_i
);

  // ---------------------------------------------------------------------------
  // Engine states.
  // ---------------------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RX   = 3'b010;
  localparam [2:0] ST_TX   = 3'b100;

  reg  [2:0]       state_ff;
  reg  [2:0]       nxt_state;
  reg              rx_en_ff;
  reg              tx_en_ff;
  reg              nxt_rx_en;
  reg              nxt_tx_en;
  reg  [31:0]      rdata_ff;
  reg  [31:0]      nxt_rdata;
  reg              mem_req_ff;
  reg              mem_we_ff;
  reg  [PTR_W-1:0] mem_addr_ff;
  reg  [1:0]       mem_size_ff;
  reg  [31:0]      mem_wdata_ff;
  reg  [31:0]      tx_data_ff;
  reg  [PTR_W-1:0] incr;
  wire [11:0]      off;
  wire             wr_rx_ptr;
  wire             wr_rx_cnt;
  wire             wr_tx_ptr;
  wire             wr_tx_cnt;
  wire             wr_rx_nptr;
  wire             wr_rx_ncnt;
  wire             wr_tx_nptr;
  wire             wr_tx_ncnt;
  wire             wr_ctl;
  wire             rx_step;
  wire             tx_step;
  wire             rx_go;
  wire             tx_go;
  wire [PTR_W-1:0] rx_ptr;
  wire [15:0]      rx_cnt;
  wire [PTR_W-1:0] rx_nptr;
  wire [15:0]      rx_ncnt;
  wire [PTR_W-1:0] tx_ptr;
  wire [15:0]      tx_cnt;
  wire [PTR_W-1:0] tx_nptr;
  wire [15:0]      tx_ncnt;

  // ---------------------------------------------------------------------------
  // Address decode: only the offset within this peripheral's window matters.
  // ---------------------------------------------------------------------------
  assign off        = reg_addr_i[11:0];
  assign wr_rx_ptr  = reg_we_i && (off == `PTE_OFF_RX_PTR);
  assign wr_rx_cnt  = reg_we_i && (off == `PTE_OFF_RX_CNT);
  assign wr_tx_ptr  = reg_we_i && (off == `PTE_OFF_TX_PTR);
  assign wr_tx_cnt  = reg_we_i && (off == `PTE_OFF_TX_CNT);
  assign wr_rx_nptr = reg_we_i && (off == `PTE_OFF_RX_NPTR);
  assign wr_rx_ncnt = reg_we_i && (off == `PTE_OFF_RX_NCNT);
  assign wr_tx_nptr = reg_we_i && (off == `PTE_OFF_TX_NPTR);
  assign wr_tx_ncnt = reg_we_i && (off == `PTE_OFF_TX_NCNT);
  assign wr_ctl     = reg_we_i && (off == `PTE_OFF_CONTROL);

  // ---------------------------------------------------------------------------
  // Pointer step for the selected transfer size.
  // ---------------------------------------------------------------------------
  always @* begin
    case (xfer_size_i)
      `PTE_SIZE_BYTE: incr = `PTE_INC_BYTE;
      `PTE_SIZE_HALF: incr = `PTE_INC_HALF;
      default:        incr = `PTE_INC_WORD;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Channels: receive and transmit share one parameterised implementation.
  // ---------------------------------------------------------------------------
  pte_chan #(
    .PTR_W (PTR_W)
  ) u_rx (
    .clk_i      (clk_i),
    .srst_i     (srst_i),
    .wr_ptr_i   (wr_rx_ptr),
    .wr_cnt_i   (wr_rx_cnt),
    .wr_nptr_i  (wr_rx_nptr),
    .wr_ncnt_i  (wr_rx_ncnt),
    .wdata_i    (reg_wdata_i),
    .step_i     (rx_step),
    .incr_i     (incr),
    .ptr_o      (rx_ptr),
    .cnt_o      (rx_cnt),
    .nptr_o     (rx_nptr),
    .ncnt_o     (rx_ncnt),
    .end_o      (rx_buffer_done_o),
    .all_done_o (rx_all_buffers_full_o)
  );

  pte_chan #(
    .PTR_W (PTR_W)
  ) u_tx (
    .clk_i      (clk_i),
    .srst_i     (srst_i),
    .wr_ptr_i   (wr_tx_ptr),
    .wr_cnt_i   (wr_tx_cnt),
    .wr_nptr_i  (wr_tx_nptr),
    .wr_ncnt_i  (wr_tx_ncnt),
    .wdata_i    (reg_wdata_i),
    .step_i     (tx_step),
    .incr_i     (incr),
    .ptr_o      (tx_ptr),
    .cnt_o      (tx_cnt),
    .nptr_o     (tx_nptr),
    .ncnt_o     (tx_ncnt),
    .end_o      (tx_buffer_done_o),
    .all_done_o (tx_all_buffers_empty_o)
  );

  // ---------------------------------------------------------------------------
  // Enable control: a disable bit overrides an enable bit in the same write.
  // ---------------------------------------------------------------------------
  always @* begin
    nxt_rx_en = rx_en_ff;
    nxt_tx_en = tx_en_ff;
    if (wr_ctl) begin
      if (reg_wdata_i[`PTE_BIT_RX_OFF]) begin
        nxt_rx_en = 1'b0;
      end else if (reg_wdata_i[`PTE_BIT_RX_ON]) begin
        nxt_rx_en = 1'b1;
      end
      if (reg_wdata_i[`PTE_BIT_TX_OFF]) begin
        nxt_tx_en = 1'b0;
      end else if (reg_wdata_i[`PTE_BIT_TX_ON]) begin
        nxt_tx_en = 1'b1;
      end
    end
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      rx_en_ff <= 1'b0;
      tx_en_ff <= 1'b0;
    end else begin
      rx_en_ff <= nxt_rx_en;
      tx_en_ff <= nxt_tx_en;
    end
  end

  // ---------------------------------------------------------------------------
  // Register read mux; unmapped and write-only offsets read as zero.
  // ---------------------------------------------------------------------------
  always @* begin
    nxt_rdata = `PTE_RST_WORD;
    if (reg_re_i) begin
      case (off)
        `PTE_OFF_RX_PTR:  nxt_rdata = rx_ptr;
        `PTE_OFF_RX_CNT:  nxt_rdata = {16'h0000, rx_cnt};
        `PTE_OFF_TX_PTR:  nxt_rdata = tx_ptr;
        `PTE_OFF_TX_CNT:  nxt_rdata = {16'h0000, tx_cnt};
        `PTE_OFF_RX_NPTR: nxt_rdata = rx_nptr;
        `PTE_OFF_RX_NCNT: nxt_rdata = {16'h0000, rx_ncnt};
        `PTE_OFF_TX_NPTR: nxt_rdata = tx_nptr;
        `PTE_OFF_TX_NCNT: nxt_rdata = {16'h0000, tx_ncnt};
        `PTE_OFF_STATUS: begin
          nxt_rdata[`PTE_BIT_RX_STATE] = rx_en_ff;
          nxt_rdata[`PTE_BIT_TX_STATE] = tx_en_ff;
        end
        default:          nxt_rdata = `PTE_RST_WORD;
      endcase
    end
  end

  // Read data stand for one cycle after the strobe, zero otherwise.
  always @(posedge clk_i) begin
    if (srst_i) begin
      rdata_ff <= `PTE_RST_WORD;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_o = rdata_ff;

  // ---------------------------------------------------------------------------
  // Transfer engine. Receive requests are served before transmit requests.
  // A channel only moves data while enabled and its count is nonzero.
  // ---------------------------------------------------------------------------
  assign rx_go   = peripheral_rx_request_i && rx_en_ff && (rx_cnt != `PTE_RST_CNT);
  assign tx_go   = peripheral_tx_request_i && tx_en_ff && (tx_cnt != `PTE_RST_CNT);
  assign rx_step = (state_ff == ST_RX) && mem_ack_i;
  assign tx_step = (state_ff == ST_TX) && mem_ack_i;

  always @* begin
    case (state_ff)
      ST_IDLE: begin
        if (rx_go) begin
          nxt_state = ST_RX;
        end else if (tx_go) begin
          nxt_state = ST_TX;
        end else begin
          nxt_state = ST_IDLE;
        end
      end
      ST_RX:   nxt_state = mem_ack_i ? ST_IDLE : ST_RX;
      ST_TX:   nxt_state = mem_ack_i ? ST_IDLE : ST_TX;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Bus request registers: launched from idle, dropped on the acknowledge.
  always @(posedge clk_i) begin
    if (srst_i) begin
      state_ff     <= ST_IDLE;
      mem_req_ff   <= 1'b0;
      mem_we_ff    <= 1'b0;
      mem_addr_ff  <= `PTE_RST_PTR;
      mem_size_ff  <= `PTE_SIZE_WORD;
      mem_wdata_ff <= `PTE_RST_WORD;
      tx_data_ff   <= `PTE_RST_WORD;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_IDLE) begin
        if (rx_go) begin
          mem_req_ff   <= 1'b1;
          mem_we_ff    <= 1'b1;
          mem_addr_ff  <= rx_ptr;
          mem_size_ff  <= xfer_size_i;
          mem_wdata_ff <= rx_data_i;
        end else if (tx_go) begin
          mem_req_ff  <= 1'b1;
          mem_we_ff   <= 1'b0;
          mem_addr_ff <= tx_ptr;
          mem_size_ff <= xfer_size_i;
        end
      end else if (mem_ack_i) begin
        mem_req_ff <= 1'b0;
        mem_we_ff  <= 1'b0;
      end
      if (tx_step) begin
        tx_data_ff <= mem_rdata_i;
      end
    end
  end

  assign rx_taken_o  = rx_step;
  assign tx_load_o   = tx_step;
  assign tx_data_o   = tx_data_ff;
  assign mem_req_o   = mem_req_ff;
  assign mem_we_o    = mem_we_ff;
  assign mem_addr_o  = mem_addr_ff;
  assign mem_size_o  = mem_size_ff;
  assign mem_wdata_o = mem_wdata_ff;

endmodule

// ### hw/pte_defines.vh
// Constants for the peripheral transfer engine: register offsets, control and
// status bit positions, reset values and transfer size codes.
// Assumes it is included by bare name from the design files of the block.
`ifndef PTE_DEFINES_VH
`define PTE_DEFINES_VH

// ----------------------------------------------------------------------------
// Register offsets within the peripheral's own address window
// ----------------------------------------------------------------------------
`define PTE_OFF_RX_PTR       12'h0100
`define PTE_OFF_RX_CNT       12'h0104
`define PTE_OFF_TX_PTR       12'h0108
`define PTE_OFF_TX_CNT       12'h010C
`define PTE_OFF_RX_NPTR      12'h0110
`define PTE_OFF_RX_NCNT      12'h0114
`define PTE_OFF_TX_NPTR      12'h0118
`define PTE_OFF_TX_NCNT      12'h011C
`define PTE_OFF_CONTROL      12'h0120
`define PTE_OFF_STATUS       12'h0124

// ----------------------------------------------------------------------------
// Control (write-only) and status (read-only) bit positions
// ----------------------------------------------------------------------------
`define PTE_BIT_RX_ON        0
`define PTE_BIT_RX_OFF       1
`define PTE_BIT_TX_ON        8
`define PTE_BIT_TX_OFF       9
`define PTE_BIT_RX_STATE     0
`define PTE_BIT_TX_STATE     8

// ----------------------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------------------
`define PTE_RST_PTR          32'h0000_0000
`define PTE_RST_CNT          16'h0000
`define PTE_RST_WORD         32'h0000_0000
`define PTE_CNT_ONE          16'h0001
`define PTE_CNT_W            16

// ----------------------------------------------------------------------------
// Transfer size codes: byte, half-word, word
// ----------------------------------------------------------------------------
`define PTE_SIZE_BYTE        2'h0
`define PTE_SIZE_HALF        2'h1
`define PTE_SIZE_WORD        2'h2
`define PTE_INC_BYTE         32'h0000_0001
`define PTE_INC_HALF         32'h0000_0002
`define PTE_INC_WORD         32'h0000_0004

`endif

// ### hw/pte_chan.v
// One transfer channel: current and next pointer, current and next count,
// the end-of-buffer flag and the all-buffers-done level.
// Assumes one clock, synchronous active-high reset, and a parent that gives
// one-cycle write strobes and one-cycle transfer-done steps.
`include "pte_defines.vh"

module pte_chan #(
  parameter PTR_W = 32
) (
  input  wire             clk_i,
  input  wire             srst_i,
  input  wire             wr_ptr_i,
  input  wire             wr_cnt_i,
  input  wire             wr_nptr_i,
  input  wire             wr_ncnt_i,
  input  wire [31:0]      wdata_i,
  input  wire             step_i,
  input  wire [PTR_W-1:0] incr_i,
  output wire [PTR_W-1:0] ptr_o,
  output wire [15:0]      cnt_o,
  output wire [PTR_W-1:0] nptr_o,
  output wire [15:0]      ncnt_o,
  output wire             end_o,
  output wire             all_done_o
);

  reg  [PTR_W-1:0] ptr_ff;
  reg  [15:0]      cnt_ff;
  reg  [PTR_W-1:0] nptr_ff;
  reg  [15:0]      ncnt_ff;
  reg              end_ff;
  reg  [PTR_W-1:0] nxt_ptr;
  reg  [15:0]      nxt_cnt;
  reg  [PTR_W-1:0] nxt_nptr;
  reg  [15:0]      nxt_ncnt;
  reg              nxt_end;
  wire             cnt_zero;
  wire             reload;
  wire             hits_zero;

  assign cnt_zero   = (cnt_ff == `PTE_RST_CNT);
  // Chain to the next buffer when the current one is spent and a next one waits, except in a cycle that writes any of the channel's registers.
  assign reload     = cnt_zero && (ncnt_ff != `PTE_RST_CNT) && !wr_cnt_i && !wr_ptr_i && !wr_nptr_i && !wr_ncnt_i;
  assign hits_zero  = step_i && (cnt_ff == `PTE_CNT_ONE) && !wr_cnt_i;

  // ---------------------------------------------------------------------------
  // Next-state logic: software writes win over hardware updates of a register.
  // ---------------------------------------------------------------------------
  always @* begin
    nxt_ptr  = ptr_ff;
    nxt_cnt  = cnt_ff;
    nxt_nptr = nptr_ff;
    nxt_ncnt = ncnt_ff;
    nxt_end  = end_ff;
    if (step_i && !cnt_zero) begin
      nxt_ptr = ptr_ff + incr_i;
      nxt_cnt = cnt_ff - `PTE_CNT_ONE;
    end
    if (reload) begin
      nxt_ptr  = nptr_ff;
      nxt_cnt  = ncnt_ff;
      nxt_ncnt = `PTE_RST_CNT;
    end
    if (wr_ptr_i) begin
      nxt_ptr = wdata_i[PTR_W-1:0];
    end
    if (wr_cnt_i) begin
      nxt_cnt = wdata_i[15:0];
    end
    if (wr_nptr_i) begin
      nxt_nptr = wdata_i[PTR_W-1:0];
    end
    if (wr_ncnt_i) begin
      nxt_ncnt = wdata_i[15:0];
    end
    // A write to either count clears the end flag; reaching zero in the same cycle sets it unless that write is to the current count.
    if (wr_cnt_i || wr_ncnt_i) begin
      nxt_end = 1'b0;
    end
    if (hits_zero) begin
      nxt_end = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Channel state registers.
  // ---------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (srst_i) begin
      ptr_ff  <= `PTE_RST_PTR;
      cnt_ff  <= `PTE_RST_CNT;
      nptr_ff <= `PTE_RST_PTR;
      ncnt_ff <= `PTE_RST_CNT;
      end_ff  <= 1'b1;
    end else begin
      ptr_ff  <= nxt_ptr;
      cnt_ff  <= nxt_cnt;
      nptr_ff <= nxt_nptr;
      ncnt_ff <= nxt_ncnt;
      end_ff  <= nxt_end;
    end
  end

  assign ptr_o      = ptr_ff;
  assign cnt_o      = cnt_ff;
  assign nptr_o     = nptr_ff;
  assign ncnt_o     = ncnt_ff;
  assign end_o      = end_ff;
  assign all_done_o = cnt_zero && (ncnt_ff == `PTE_RST_CNT);

endmodule

// ### test/pte_monitor.sv
// Checker for the peripheral transfer engine top level.
// Assumes it is bound to pte_top and sees only that module's ports.
module pte_monitor #(
  parameter ADDR_W = 12,
  parameter PTR_W  = 32
) (
  input wire              clk_i,
  input wire              srst_i,
  input wire [ADDR_W-1:0] reg_addr_i,
  input wire [31:0]       reg_wdata_i,
  input wire              reg_we_i,
  input wire              reg_re_i,
  input wire [31:0]       reg_rdata_o,
  input wire              rx_taken_o,
  input wire              tx_load_o,
  input wire              rx_buffer_done_o,
  input wire              tx_all_buffers_empty_o,
  input wire              mem_req_o,
  input wire              mem_we_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // ----------------------------------------------------------------------
  // Control writes seen in the status read that follows at once
  // ----------------------------------------------------------------------
  sequence s_stat_rd;
    reg_re_i && reg_addr_i == 12'h0124;
  endsequence
  sequence s_ctl_wr;
    reg_we_i && reg_addr_i == 12'h0120;
  endsequence
  property p_rx_on;
    s_ctl_wr ##0 reg_wdata_i[0] && !reg_wdata_i[1] ##1 s_stat_rd |=> reg_rdata_o[0];
  endproperty
  a_rx_on: assert property (p_rx_on) else $error("receive enable missing in status");
  property p_rx_off;
    s_ctl_wr ##0 reg_wdata_i[1] ##1 s_stat_rd |=> !reg_rdata_o[0];
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("receive still enabled");
  property p_tx_on;
    s_ctl_wr ##0 reg_wdata_i[8] && !reg_wdata_i[9] ##1 s_stat_rd |=> reg_rdata_o[8];
  endproperty
  a_tx_on: assert property (p_tx_on) else $error("transmit enable missing in status");
  property p_tx_off;
    s_ctl_wr ##0 reg_wdata_i[9] ##1 s_stat_rd |=> !reg_rdata_o[8];
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("transmit still enabled");

  // ----------------------------------------------------------------------
  // Counts, flags and transfer launch
  // ----------------------------------------------------------------------
  property p_cnt_hi;
    reg_re_i && reg_addr_i[11:5] == 7'h08 && reg_addr_i[2] |=> reg_rdata_o[31:16] == 16'h0000;
  endproperty
  a_cnt_hi: assert property (p_cnt_hi) else $error("count upper half not zero");
  property p_tx_stop;
    tx_all_buffers_empty_o && !mem_req_o |=> !mem_req_o || mem_we_o;
  endproperty
  a_tx_stop: assert property (p_tx_stop) else $error("transmit launched at zero count");
  property p_rx_end;
    $rose(rx_buffer_done_o) |-> $past(rx_taken_o);
  endproperty
  a_rx_end: assert property (p_rx_end) else $error("receive end flag without a transfer");
  property p_rx_clr;
    reg_we_i && (reg_addr_i == 12'h0104 || reg_addr_i == 12'h0114) && !rx_taken_o |=> !rx_buffer_done_o;
  endproperty
  a_rx_clr: assert property (p_rx_clr) else $error("receive end flag not cleared");

  // Main scenarios reached.
  c_rx: cover property (rx_taken_o);
  c_tx: cover property (tx_load_o);
  c_end: cover property ($rose(rx_buffer_done_o));
endmodule

bind pte_top pte_monitor #(.ADDR_W(ADDR_W), .PTR_W(PTR_W)) i_pte_monitor (.*);

// ### test/pte_host_peripheral_prefix_model.sv
// Serial peripheral model that raises receive and transmit requests.
// Assumes one clock, synchronous reset, and the engine's one-cycle service pulses.
module pte_host_peripheral_prefix_model (
  input  wire         clk_i,
  input  wire         srst_i,
  input  wire         load_i,
  input  wire         slow_i,
  input  wire  [7:0]  rx_num_i,
  input  wire  [7:0]  tx_num_i,
  input  wire         rx_taken_i,
  input  wire         tx_load_i,
  input  wire  [31:0] tx_data_i,
  output logic        rx_req_o,
  output logic        tx_req_o,
  output logic [31:0] rx_data_o,
  output logic [7:0]  rx_left_o,
  output logic [7:0]  tx_left_o,
  output logic [31:0] tx_last_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rx_val_ff = 32'h0000_0C00;
  logic [1:0]  rx_gap_ff = 2'h0;
  logic [1:0]  tx_gap_ff = 2'h0;
  logic        tx_seen_ff = 1'b0;

  // Quiet lines until the first reset edge.
  initial begin
    rx_req_o = 1'b0;
    tx_req_o = 1'b0;
    rx_left_o = 8'h00;
    tx_left_o = 8'h00;
  end
  // A released data line shows the inverse of the held character.
  assign rx_data_o = rx_req_o ? rx_val_ff : ~rx_val_ff;

  // Each request drops at the edge ending its service, then waits a three-cycle gap when slow_i is set.
  always @(posedge clk_i) begin
    tx_seen_ff <= tx_load_i;
    if (tx_seen_ff) begin
      tx_last_o <= tx_data_i;
    end
    if (srst_i) begin
      rx_req_o <= 1'b0;
      tx_req_o <= 1'b0;
      rx_left_o <= 8'h00;
      tx_left_o <= 8'h00;
    end else begin
      if (rx_taken_i) begin
        rx_left_o <= rx_left_o - 8'h01;
        rx_val_ff <= rx_val_ff + 32'h0000_0001;
        rx_req_o <= 1'b0;
        rx_gap_ff <= slow_i ? 2'h3 : 2'h0;
      end else if (load_i) begin
        rx_left_o <= rx_num_i;
      end else if (rx_gap_ff != 2'h0) begin
        rx_gap_ff <= rx_gap_ff - 2'h1;
      end else begin
        rx_req_o <= rx_left_o != 8'h00;
      end
      if (tx_load_i) begin
        tx_left_o <= tx_left_o - 8'h01;
        tx_req_o <= 1'b0;
        tx_gap_ff <= slow_i ? 2'h3 : 2'h0;
      end else if (load_i) begin
        tx_left_o <= tx_num_i;
      end else if (tx_gap_ff != 2'h0) begin
        tx_gap_ff <= tx_gap_ff - 2'h1;
      end else begin
        tx_req_o <= tx_left_o != 8'h00;
      end
    end
  end
endmodule

// ### test/pte_top_test.sv
// Self-checking testbench for the peripheral transfer engine.
// Assumes the peripheral model and the bound checker are compiled first.
module pte_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [11:0] reg_addr_i = 12'h000;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic        reg_we_i = 1'b0;
  logic        reg_re_i = 1'b0;
  logic [1:0]  xfer_size_i = 2'h2;
  logic [31:0] mem_rdata_i = 32'h0000_0000;
  logic        mem_ack_i = 1'b0;
  logic        load = 1'b0;
  logic        slow = 1'b0;
  logic [7:0]  rx_num = 8'h00;
  logic [7:0]  tx_num = 8'h00;
  logic [7:0]  rx_left, tx_left;
  logic [31:0] reg_rdata_o, tx_data_o, mem_addr_o, mem_wdata_o, rx_data_i, tx_last, rd, v;
  logic        rx_taken_o, tx_load_o, peripheral_rx_request_i, peripheral_tx_request_i, mem_req_o, mem_we_o;
  logic        rx_buffer_done_o, rx_all_buffers_full_o, tx_buffer_done_o, tx_all_buffers_empty_o;
  logic [1:0]  mem_size_o;
  logic [31:0] log_a [0:7];
  logic [31:0] log_d [0:7];
  logic [31:0] ctl_w [0:5] = '{32'h001, 32'h000, 32'h003, 32'h101, 32'h000, 32'h302};
  logic [31:0] ctl_e [0:5] = '{32'h001, 32'h001, 32'h000, 32'h101, 32'h101, 32'h000};
  int          n_log = 0, lat = 0, wcnt = 0, i, err_total = 0, n_tests = 0;
  wire         go = mem_req_o === 1'b1 && !mem_ack_i && wcnt >= lat;
  wire  [31:0] flags = {28'h0, rx_buffer_done_o, rx_all_buffers_full_o, tx_buffer_done_o, tx_all_buffers_empty_o};

  pte_top i_pte_top (.*);
  pte_host_peripheral_prefix_model i_pte_host_peripheral_prefix_model (
    .clk_i(clk_i), .srst_i(srst_i), .load_i(load), .slow_i(slow), .rx_num_i(rx_num), .tx_num_i(tx_num),
    .rx_taken_i(rx_taken_o), .tx_load_i(tx_load_o), .tx_data_i(tx_data_o), .rx_req_o(peripheral_rx_request_i),
    .tx_req_o(peripheral_tx_request_i), .rx_data_o(rx_data_i), .rx_left_o(rx_left), .tx_left_o(tx_left),
    .tx_last_o(tx_last));

  always #2 clk_i = ~clk_i;
  // Memory answers after lat wait cycles, logs writes, and scrambles idle read data.
  always @(posedge clk_i) begin
    mem_ack_i <= go;
    if (go) chk(mem_size_o, {30'h0, xfer_size_i});
    mem_rdata_i <= go ? mem_addr_o ^ 32'h5A5A_0000 : ~mem_rdata_i;
    wcnt <= go ? 0 : (mem_req_o === 1'b1 && !mem_ack_i) ? wcnt + 1 : wcnt;
    if (go && mem_we_o === 1'b1 && n_log < 8) begin
      log_a[n_log] <= mem_addr_o;
      log_d[n_log] <= mem_wdata_o;
      n_log <= n_log + 1;
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus cycles: each task starts right after a rising edge.
  task automatic strobe_wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask
  task automatic reg_rd(input logic [11:0] a, output logic [31:0] q);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    @(negedge clk_i);
    q = reg_rdata_o;
    @(posedge clk_i);
  endtask
  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    strobe_wr(a, d);
    @(posedge clk_i);
  endtask
  // Hands the peripheral new characters, then waits for the traffic to end.
  task automatic feed(input logic [7:0] r, input logic [7:0] t, input logic [7:0] rt, input logic [7:0] tt);
    rx_num <= r;
    tx_num <= t;
    load <= 1'b1;
    @(posedge clk_i);
    load <= 1'b0;
    repeat (2) @(posedge clk_i);
    for (i = 0; i < 400; i++) begin
      @(posedge clk_i);
      if (rx_left === rt && tx_left === tt && mem_req_o === 1'b0) break;
    end
    if (i == 400) begin
      err_total++;
      $display("mismatch at %0t: traffic did not settle", $time);
      close_out();
    end
    repeat (3) @(posedge clk_i);
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    chk(flags, 32'h0000_000F);
    for (i = 0; i < 11; i++) begin
      reg_rd(12'h100 + 12'(i * 4), rd);
      chk(rd, 32'h0000_0000);
    end
    // Read back every pointer and count; counts keep only sixteen bits.
    for (i = 0; i < 8; i++) begin
      v = 32'hA5C3_7E10 + 32'(i);
      reg_wr(12'h100 + 12'(i * 4), v);
      reg_rd(12'h100 + 12'(i * 4), rd);
      chk(rd, i[0] ? v & 32'h0000_FFFF : v);
    end
    reg_wr(12'h124, 32'hFFFF_FFFF);
    reg_rd(12'h124, rd);
    chk(rd, 32'h0000_0000);
    for (i = 0; i < 4; i++) reg_wr(12'h114 + 12'(i[0] * 8) - 12'(i[1] * 16), 32'h0000_0000);
    chk(flags, 32'h0000_0005);
    for (i = 0; i < 6; i++) begin
      strobe_wr(12'h120, ctl_w[i]);
      reg_rd(12'h124, rd);
      chk(rd, ctl_e[i]);
    end
    // Receive two words, then chain into a one-word next buffer.
    reg_wr(12'h100, 32'h0000_1000);
    reg_wr(12'h104, 32'h0000_0002);
    reg_wr(12'h110, 32'h0000_2000);
    reg_wr(12'h114, 32'h0000_0001);
    reg_wr(12'h120, 32'h0000_0001);
    feed(8'h03, 8'h00, 8'h00, 8'h00);
    chk(n_log, 3);
    for (i = 0; i < 3; i++) begin
      chk(log_a[i], i == 2 ? 32'h0000_2000 : 32'h0000_1000 + 32'(i * 4));
      chk(log_d[i], 32'h0000_0C00 + 32'(i));
    end
    reg_rd(12'h100, rd);
    chk(rd, 32'h0000_2004);
    reg_rd(12'h114, rd);
    chk(rd, 32'h0000_0000);
    chk(flags, 32'h0000_000D);
    // Half-word transmit against slow memory stops when its count runs out.
    lat = 3;
    slow <= 1'b1;
    xfer_size_i <= 2'h1;
    reg_wr(12'h108, 32'h0000_3000);
    reg_wr(12'h10C, 32'h0000_0002);
    reg_wr(12'h120, 32'h0000_0100);
    feed(8'h00, 8'h03, 8'h00, 8'h01);
    repeat (30) @(posedge clk_i);
    chk(tx_left, 32'h0000_0001);
    reg_rd(12'h108, rd);
    chk(rd, 32'h0000_3004);
    chk(tx_last, 32'h5A5A_3002);
    chk(flags, 32'h0000_000F);
    // A single byte receive advances the pointer by one.
    xfer_size_i <= 2'h0;
    reg_wr(12'h100, 32'h0000_0010);
    reg_wr(12'h104, 32'h0000_0001);
    feed(8'h01, 8'h01, 8'h00, 8'h01);
    reg_rd(12'h100, rd);
    chk(rd, 32'h0000_0011);
    close_out();
  end
endmodule
